// File: rtl/atm_top.sv
// The APB slave port and the address map were decided locally.
module atm_top #(
  parameter int unsigned MS_CYCLES = atm_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [atm_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // terminal functions and drive state
  input wire logic [2:0] start_term_i,
  input wire logic [2:0] reset_term_i,
  input wire logic [2:0] gate_term_i,
  input wire logic drive_run_i,
  // timer outputs
  output logic [2:0] timer_out_o
);
  import atm_pkg::*;

  typedef struct packed {
    logic [2:0][15:0] mode;
    logic [2:0][15:0] cyc;
    logic [2:0][15:0] cmp;
    logic [11:0] gate;
    logic [11:0] osel;
    atm_tmr_s [2:0] tmr;
    logic run_q;
    logic [2:0] st_q;
    logic [2:0] rs_q;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } atm_top_s;

  atm_top_s s_r;
  atm_top_s s_nxt;
  logic ms_tk;
  logic sec_tk;
  logic min_tk;
  logic [9:0] pin_lvl;
  logic run_lvl;
  logic [2:0] st_lvl;
  logic [2:0] rs_lvl;
  logic [2:0] gt_lvl;
  logic [2:0] tk;
  logic [2:0] st_ev;
  logic [2:0] rs_ev;
  logic [2:0] cmp_ev;
  logic [2:0] cyc_ev;
  logic [2:0] adv;

  atm_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ms_o(ms_tk),
    .sec_o(sec_tk),
    .min_o(min_tk)
  );

  atm_sync #(
    .W(10)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i({gate_term_i, reset_term_i, start_term_i, drive_run_i}),
    .lvl_o(pin_lvl)
  );

  assign {gt_lvl, rs_lvl, st_lvl, run_lvl} = pin_lvl;

  always_comb
  begin
    atm_tmr_s t;
    logic [3:0] clk_c;
    logic [3:0] st_c;
    logic [3:0] rs_c;
    logic [3:0] cy_c;
    logic [3:0] gt_c;
    logic [3:0] oc;
    logic [15:0] cmp_eff;
    logic [16:0] nx;
    logic gopen;
    logic pe;
    logic acc;
    logic wr;
    logic hit;
    logic [31:0] rd;
    t = '0;
    clk_c = '0;
    st_c = '0;
    rs_c = '0;
    cy_c = '0;
    gt_c = '0;
    oc = '0;
    cmp_eff = '0;
    nx = '0;
    gopen = 1'b0;
    pe = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    hit = 1'b0;
    rd = '0;
    s_nxt = s_r;
    tk = '0;
    st_ev = '0;
    rs_ev = '0;
    cmp_ev = '0;
    cyc_ev = '0;
    adv = '0;
    // later timers read the events of earlier ones in the same cycle
    for (int i = 0; i < NUM_TMR; i++)
    begin
      clk_c = s_r.mode[i][MODE_CLK_LSB +: 4];
      st_c = s_r.mode[i][MODE_ST_LSB +: 4];
      rs_c = s_r.mode[i][MODE_RS_LSB +: 4];
      cy_c = s_r.mode[i][MODE_CY_LSB +: 4];
      gt_c = s_r.gate[i*4 +: 4];
      oc = s_r.osel[i*4 +: 4];
      cmp_eff = (s_r.cmp[i] > s_r.cyc[i]) ? s_r.cyc[i] : s_r.cmp[i]; // RL17
      case (clk_c)
        CLK_MS: tk[i] = ms_tk; // RL1
        CLK_SEC: tk[i] = sec_tk; // RL1
        CLK_MIN: tk[i] = min_tk; // RL1
        CLK_T1CYC: tk[i] = (i > 0) && cyc_ev[0]; // RL2
        CLK_T2CYC: tk[i] = (i > 1) && cyc_ev[1]; // RL3
        default: tk[i] = 1'b0;
      endcase
      // gates naming the timer itself or a later one are treated as open
      case (gt_c)
        GT_TERM: gopen = gt_lvl[i]; // RL20
        GT_T1CMP: gopen = (i > 0) ? s_r.tmr[0].cmp_f : 1'b1; // RL20
        GT_T1CYC: gopen = (i > 0) ? s_r.tmr[0].cyc_f : 1'b1; // RL20
        GT_T2CMP: gopen = (i > 1) ? s_r.tmr[1].cmp_f : 1'b1; // RL20
        GT_T2CYC: gopen = (i > 1) ? s_r.tmr[1].cyc_f : 1'b1; // RL20
        default: gopen = 1'b1; // RL20
      endcase
      case (st_c)
        ST_TERM: st_ev[i] = st_lvl[i] && !s_r.st_q[i]; // RL4
        ST_RUN: st_ev[i] = run_lvl && !s_r.run_q; // RL5
        ST_STOP: st_ev[i] = !run_lvl && s_r.run_q; // RL6
        ST_T1SYNC: st_ev[i] = (i > 0) && st_ev[0]; // RL7
        ST_T1CYC: st_ev[i] = (i > 0) && cyc_ev[0]; // RL8
        ST_T2CYC: st_ev[i] = (i > 1) && cyc_ev[1]; // RL9
        default: st_ev[i] = 1'b0;
      endcase
      rs_ev[i] = (rs_c == RS_TERM) && rs_lvl[i] && !s_r.rs_q[i]; // RL10
      t = s_r.tmr[i];
      if (rs_ev[i])
      begin
        t.cnt = '0; // RL10
        t.cmp_f = 1'b0;
        t.cyc_f = 1'b0;
      end
      if (st_ev[i])
        t.run = 1'b1;
      adv[i] = t.run && tk[i] && gopen;
      if (adv[i])
      begin
        nx = {1'b0, t.cnt} + 17'h1; // RL21
        cmp_ev[i] = (nx == {1'b0, cmp_eff}); // RL17
        cyc_ev[i] = (nx >= {1'b0, s_r.cyc[i]}); // RL21
        t.cnt = nx[15:0];
        if (cyc_ev[i])
        begin
          if (cy_c == CY_MULTI || rs_c == RS_CYC)
          begin
            t.cnt = '0; // RL14 RL11
            t.cmp_f = 1'b0;
          end
          else
            t.cnt = s_r.cyc[i];
          if (cy_c != CY_MULTI)
            t.run = 1'b0; // RL13
        end
        // a flag set by this tick survives any clear in the same cycle
        t.cmp_f = t.cmp_f || cmp_ev[i];
        t.cyc_f = t.cyc_f || cyc_ev[i]; // RL21
      end
      if (rs_c == RS_STOP && s_r.tmr[i].run && !t.run)
      begin
        t.cnt = '0; // RL12
        t.cmp_f = cmp_ev[i];
        t.cyc_f = cyc_ev[i];
      end
      if (ms_tk && t.half != '0)
        t.half = t.half - 9'h1;
      pe = 1'b0;
      case (oc)
        OUT_CMP_PLS: pe = cmp_ev[i]; // RL18
        OUT_CMP_LVL: t.out = t.cmp_f; // RL18
        OUT_CMP_TGL: t.out = t.out ^ cmp_ev[i]; // RL18
        OUT_CYC_PLS: pe = cyc_ev[i]; // RL19
        OUT_CYC_LVL: t.out = t.cyc_f; // RL19
        OUT_CYC_TGL: t.out = t.out ^ cyc_ev[i]; // RL19
        OUT_ANY_TGL: t.out = t.out ^ (cmp_ev[i] || cyc_ev[i]); // RL19
        default: t.out = 1'b0;
      endcase
      if (pe)
        t.half = HALF_MS;
      if (oc == OUT_CMP_PLS || oc == OUT_CYC_PLS)
        t.out = (t.half != '0);
      s_nxt.tmr[i] = t;
    end
    s_nxt.run_q = run_lvl;
    s_nxt.st_q = st_lvl; // RL22
    s_nxt.rs_q = rs_lvl; // RL22
    // one wait state: read data is caught in the first access cycle, write data in the second
    acc = psel_i && penable_i;
    wr = acc && s_r.ready && pwrite_i;
    for (int i = 0; i < NUM_TMR; i++)
    begin
      if (paddr_i == OFS_MODE0 + OFS_STEP * 8'(i))
      begin
        hit = 1'b1;
        rd[15:0] = s_r.mode[i];
        if (wr)
          s_nxt.mode[i] = pwdata_i[15:0]; // RL16
      end
      if (paddr_i == OFS_CYC0 + OFS_STEP * 8'(i))
      begin
        hit = 1'b1;
        rd[15:0] = s_r.cyc[i];
        if (wr)
          s_nxt.cyc[i] = pwdata_i[15:0]; // RL15
      end
      if (paddr_i == OFS_CMP0 + OFS_STEP * 8'(i))
      begin
        hit = 1'b1;
        rd[15:0] = s_r.cmp[i];
        if (wr)
          s_nxt.cmp[i] = pwdata_i[15:0];
      end
      if (paddr_i == OFS_STAT0 + OFS_STEP * 8'(i))
      begin
        hit = 1'b1;
        rd[15:0] = s_r.tmr[i].cnt;
        rd[STAT_RUN_BIT] = s_r.tmr[i].run;
        rd[STAT_CMP_BIT] = s_r.tmr[i].cmp_f;
        rd[STAT_CYC_BIT] = s_r.tmr[i].cyc_f;
        rd[STAT_OUT_BIT] = s_r.tmr[i].out;
      end
    end
    if (paddr_i == OFS_GATE)
    begin
      hit = 1'b1;
      rd[11:0] = s_r.gate;
      if (wr)
        s_nxt.gate = pwdata_i[11:0];
    end
    if (paddr_i == OFS_OSEL)
    begin
      hit = 1'b1;
      rd[11:0] = s_r.osel;
      if (wr)
        s_nxt.osel = pwdata_i[11:0];
    end
    s_nxt.ready = acc && !s_r.ready;
    if (acc && !s_r.ready)
    begin
      s_nxt.rdata = pwrite_i ? 32'h0 : rd;
      s_nxt.err = !hit;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      s_r <= '0;
      s_r.mode <= {NUM_TMR{MODE_RST}}; // RL16
      s_r.cyc <= {NUM_TMR{CYC_RST}}; // RL15
      s_r.cmp <= {NUM_TMR{CMP_RST}}; // RL17
      s_r.gate <= GATE_RST;
      s_r.osel <= OSEL_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata_o = s_r.rdata;
  assign pready_o = s_r.ready;
  assign pslverr_o = s_r.err;

  for (genvar g = 0; g < NUM_TMR; g++)
  begin : g_out
    assign timer_out_o[g] = s_r.tmr[g].out;
  end

  a_ms_spacing: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL1
    ms_tk |=> !ms_tk [*8])
    else $error("ms ticks too close");
  a_chain_count: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL2
    (s_r.mode[1][3:0] == CLK_T1CYC && s_r.gate[7:4] == GT_NONE && s_r.tmr[1].run
     && cyc_ev[0] && !rs_ev[1] && !cyc_ev[1])
    |=> s_r.tmr[1].cnt == $past(s_r.tmr[1].cnt) + 16'h1)
    else $error("second timer missed chained tick");
  a_run_start: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL5
    (s_r.mode[0][7:4] == ST_RUN && run_lvl && !s_r.run_q && !cyc_ev[0]) |=> s_r.tmr[0].run)
    else $error("no start on stop to run");
  a_sync_start: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL7
    (s_r.mode[1][7:4] == ST_T1SYNC && st_ev[0] && !cyc_ev[1]) |=> s_r.tmr[1].run)
    else $error("second timer not started with first");
  a_reset_clears: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL10
    (rs_ev[0] && !adv[0]) |=> (s_r.tmr[0].cnt == 16'h0 && !s_r.tmr[0].cmp_f && !s_r.tmr[0].cyc_f))
    else $error("reset left count or flags");
  a_single_stop: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL13
    (cyc_ev[0] && s_r.mode[0][15:12] == CY_SINGLE) |=> !s_r.tmr[0].run)
    else $error("single cycle timer kept running");
  a_multi_wrap: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL14
    (cyc_ev[0] && s_r.mode[0][15:12] == CY_MULTI) |=> (s_r.tmr[0].run && s_r.tmr[0].cnt == 16'h0))
    else $error("multi cycle timer did not wrap");
  a_cmp_bound: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL17
    cmp_ev[0] |-> (17'(s_r.tmr[0].cnt) + 17'h1 <= 17'(s_r.cyc[0])))
    else $error("compare event above cycle length");
  a_half_pulse: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL18
    (s_r.osel[3:0] == OUT_CMP_PLS && cmp_ev[0]) |=> timer_out_o[0] [*8])
    else $error("compare pulse too short");
  a_cycle_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL21
    cyc_ev[0] |=> s_r.tmr[0].cyc_f)
    else $error("cycle flag not set");
  a_edge_once: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RL22
    (s_r.mode[0][7:4] == ST_TERM && st_ev[0]) |=> !(s_r.mode[0][7:4] == ST_TERM && st_ev[0]))
    else $error("one edge gave two starts");
endmodule

// File: rtl/atm_pkg.sv
// What this block does
// RL1 - clock digit 0, 1, 2 picks a 1 ms, 1 s or 1 min tick
// RL2 - clock code 3 counts first timer cycle pulses, second and third timers only
// RL3 - clock code 4 counts second timer cycle pulses, third timer only
// RL4 - start code 0 starts on an edge of the start terminal function
// RL5 - start code 1 starts when the drive goes from stopped to running
// RL6 - start code 2 starts when the drive goes from running to stopped
// RL7 - start code 3 starts second or third timer together with the first
// RL8 - start code 4 starts second or third timer on first timer cycle pulse
// RL9 - start code 5 starts third timer on second timer cycle pulse
// RL10 - reset clears count and flags; reset code 0 takes the terminal function
// RL11 - reset code 1 resets the timer automatically when the cycle is reached
// RL12 - reset code 2 resets the timer automatically when it stops
// RL13 - cycle code 0 runs one cycle, then needs reset and new start
// RL14 - cycle code 1 clears the count at cycle end and keeps timing
// RL15 - cycle length 0 to 65535 ticks, default 30000
// RL16 - each timer has its own four-digit mode, all digits default zero
// RL17 - compare threshold capped at cycle length, default 10000, event on equality
// RL18 - output codes 0, 1, 2: half-second pulse, level, toggle on compare
// RL19 - codes 3, 4, 5 same on cycle end; code 6 toggles on either
// RL20 - gating code 0 none; others gate from terminal or earlier timer events
// RL21 - running timer adds one per tick, pulses once at cycle length
// RL22 - trigger pins are synchronised and edge detected, one event per edge
package atm_pkg;
  localparam int unsigned NUM_TMR = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_MS_NS = 1000000;
  localparam int unsigned MS_CYC = (TICK_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] MS_PER_S = 10'h3e8;
  localparam logic [5:0] S_PER_MIN = 6'h3c;
  localparam logic [8:0] HALF_MS = 9'h1f4;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] CYC_RST = 16'h7530;
  localparam logic [15:0] CMP_RST = 16'h2710;
  localparam logic [11:0] GATE_RST = 12'h000;
  localparam logic [11:0] OSEL_RST = 12'h111;
  localparam logic [7:0] OFS_MODE0 = 8'h00;
  localparam logic [7:0] OFS_CYC0 = 8'h0c;
  localparam logic [7:0] OFS_CMP0 = 8'h18;
  localparam logic [7:0] OFS_GATE = 8'h24;
  localparam logic [7:0] OFS_OSEL = 8'h28;
  localparam logic [7:0] OFS_STAT0 = 8'h2c;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam int unsigned MODE_CLK_LSB = 0;
  localparam int unsigned MODE_ST_LSB = 4;
  localparam int unsigned MODE_RS_LSB = 8;
  localparam int unsigned MODE_CY_LSB = 12;
  localparam int unsigned STAT_RUN_BIT = 16;
  localparam int unsigned STAT_CMP_BIT = 17;
  localparam int unsigned STAT_CYC_BIT = 18;
  localparam int unsigned STAT_OUT_BIT = 19;
  localparam logic [3:0] CLK_MS = 4'h0;
  localparam logic [3:0] CLK_SEC = 4'h1;
  localparam logic [3:0] CLK_MIN = 4'h2;
  localparam logic [3:0] CLK_T1CYC = 4'h3;
  localparam logic [3:0] CLK_T2CYC = 4'h4;
  localparam logic [3:0] ST_TERM = 4'h0;
  localparam logic [3:0] ST_RUN = 4'h1;
  localparam logic [3:0] ST_STOP = 4'h2;
  localparam logic [3:0] ST_T1SYNC = 4'h3;
  localparam logic [3:0] ST_T1CYC = 4'h4;
  localparam logic [3:0] ST_T2CYC = 4'h5;
  localparam logic [3:0] RS_TERM = 4'h0;
  localparam logic [3:0] RS_CYC = 4'h1;
  localparam logic [3:0] RS_STOP = 4'h2;
  localparam logic [3:0] CY_SINGLE = 4'h0;
  localparam logic [3:0] CY_MULTI = 4'h1;
  localparam logic [3:0] OUT_CMP_PLS = 4'h0;
  localparam logic [3:0] OUT_CMP_LVL = 4'h1;
  localparam logic [3:0] OUT_CMP_TGL = 4'h2;
  localparam logic [3:0] OUT_CYC_PLS = 4'h3;
  localparam logic [3:0] OUT_CYC_LVL = 4'h4;
  localparam logic [3:0] OUT_CYC_TGL = 4'h5;
  localparam logic [3:0] OUT_ANY_TGL = 4'h6;
  localparam logic [3:0] GT_NONE = 4'h0;
  localparam logic [3:0] GT_TERM = 4'h1;
  localparam logic [3:0] GT_T1CMP = 4'h2;
  localparam logic [3:0] GT_T1CYC = 4'h3;
  localparam logic [3:0] GT_T2CMP = 4'h4;
  localparam logic [3:0] GT_T2CYC = 4'h5;

  typedef struct packed {
    logic [15:0] cnt;
    logic run;
    logic cmp_f;
    logic cyc_f;
    logic out;
    logic [8:0] half;
  } atm_tmr_s;
endpackage

// File: rtl/atm_sync.sv
module atm_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // pins and clean levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);
  import atm_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } atm_sync_s;

  atm_sync_s s_r;
  atm_sync_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // a change is taken only once two later stages agree
    for (int b = 0; b < W; b++)
    begin
      if (s_r.s2[b] == s_r.s3[b])
        s_nxt.lvl[b] = s_r.s3[b]; // RL22
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign lvl_o = s_r.lvl;
endmodule

// File: rtl/atm_tick.sv
module atm_tick #(
  parameter int unsigned MS_CYCLES = atm_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // one-cycle tick pulses
  output logic ms_o,
  output logic sec_o,
  output logic min_o
);
  import atm_pkg::*;

  typedef struct packed {
    logic [31:0] pre;
    logic [9:0] ms;
    logic [5:0] sec;
    logic ms_tk;
    logic sec_tk;
    logic min_tk;
  } atm_tick_s;

  atm_tick_s s_r;
  atm_tick_s s_nxt;

  // seconds and minutes chain off the ms tick, so all three stay phase aligned
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ms_tk = 1'b0;
    s_nxt.sec_tk = 1'b0;
    s_nxt.min_tk = 1'b0;
    if (s_r.pre == MS_CYCLES - 1)
    begin
      s_nxt.pre = '0;
      s_nxt.ms_tk = 1'b1; // RL1
      if (s_r.ms == MS_PER_S - 10'h1)
      begin
        s_nxt.ms = '0;
        s_nxt.sec_tk = 1'b1; // RL1
        if (s_r.sec == S_PER_MIN - 6'h1)
        begin
          s_nxt.sec = '0;
          s_nxt.min_tk = 1'b1; // RL1
        end
        else
          s_nxt.sec = s_r.sec + 6'h1;
      end
      else
        s_nxt.ms = s_r.ms + 10'h1;
    end
    else
      s_nxt.pre = s_r.pre + 32'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ms_o = s_r.ms_tk;
  assign sec_o = s_r.sec_tk;
  assign min_o = s_r.min_tk;
endmodule

// File: sim/atm_term_model.sv
module atm_term_model #(
  parameter int unsigned HOLD = 8
) (
  // clock
  input wire logic clk_sys_i,
  // terminal functions and drive state
  output logic [2:0] start_term_o,
  output logic [2:0] reset_term_o,
  output logic [2:0] gate_term_o,
  output logic drive_run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    start_term_o = 3'h0;
    reset_term_o = 3'h0;
    gate_term_o = 3'h0;
    drive_run_o = 1'b0;
  end
  // held well past the pin filter so each edge is seen once
  task automatic pulse(input logic is_rst, input logic [2:0] sel);
    @(posedge clk_sys_i);
    if (is_rst)
      reset_term_o <= sel;
    else
      start_term_o <= sel;
    repeat (HOLD) @(posedge clk_sys_i);
    reset_term_o <= 3'h0;
    start_term_o <= 3'h0;
  endtask
  task automatic set_lvl(input logic [2:0] gate, input logic run);
    @(posedge clk_sys_i);
    gate_term_o <= gate;
    drive_run_o <= run;
  endtask
endmodule

// File: sim/aux_triple_timer_tb.sv
module aux_triple_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import atm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [2:0] start_term_i;
  logic [2:0] reset_term_i;
  logic [2:0] gate_term_i;
  logic drive_run_i;
  logic [2:0] timer_out_o;
  logic [31:0] rd;
  logic err;
  logic [15:0] lfsr_r = 16'h0052;
  int fail_count = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int cyc_len;
  int cmp_val;
  int exp_q[$];

  always #4 clk_sys_i = ~clk_sys_i;

  atm_top #(.MS_CYCLES(20)) uut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .start_term_i(start_term_i),
    .reset_term_i(reset_term_i), .gate_term_i(gate_term_i), .drive_run_i(drive_run_i),
    .timer_out_o(timer_out_o)
  );
  atm_term_model term (
    .clk_sys_i(clk_sys_i), .start_term_o(start_term_i), .reset_term_o(reset_term_i),
    .gate_term_o(gate_term_i), .drive_run_o(drive_run_i)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int stat_model(int cnt, int run, int cmp, int cyc, int out);
    return cnt | (run << STAT_RUN_BIT) | (cmp << STAT_CMP_BIT) | (cyc << STAT_CYC_BIT) | (out << STAT_OUT_BIT);
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // pready is registered, so its level before the edge is the sampled one
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] addr, input int exp, input logic [31:0] mask);
    apb(1'b0, addr, 32'h0);
    check(rd & mask, 32'(exp));
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    exp_q = '{0, 0, 0, 30000, 30000, 30000, 10000, 10000, 10000, 0, 'h111};
    for (int i = 0; i < 11; i++)
    begin
      rd_chk(8'(4 * i), exp_q.pop_front(), 32'hffffffff);
    end
    apb(1'b0, 8'h3c, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, OFS_STAT0, {16'h0, lfsr_r});
    rd_chk(OFS_STAT0, 0, 32'hffffffff);
    $display("test defaults done");
    // random cycle length and threshold, gated start
    lfsr_r = lfsr_next(lfsr_r);
    cyc_len = 3 + int'(lfsr_r[1:0]);
    cmp_val = 1 + int'(lfsr_r[5:2]) % cyc_len;
    apb(1'b1, OFS_CYC0, 32'(cyc_len));
    apb(1'b1, OFS_CMP0, 32'(cmp_val));
    apb(1'b1, OFS_GATE, 32'h1);
    term.pulse(1'b0, 3'h1);
    repeat (200) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0, stat_model(0, 1, 0, 0, 0), 32'hffffffff);
    term.set_lvl(3'h1, 1'b0);
    repeat (200) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0, stat_model(cyc_len, 0, 1, 1, 1), 32'hffffffff);
    check(32'(timer_out_o[0]), 32'h1);
    term.pulse(1'b1, 3'h1);
    repeat (20) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0, 0, 32'hffffffff);
    check(32'(timer_out_o[0]), 32'h0);
    term.pulse(1'b0, 3'h1);
    repeat (200) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0, stat_model(cyc_len, 0, 1, 1, 1), 32'hffffffff);
    $display("test single cycle done");
    // chain: second and third timers count first timer cycles
    apb(1'b1, OFS_GATE, 32'h0);
    apb(1'b1, OFS_MODE0, 32'h1010);
    apb(1'b1, OFS_MODE0 + 8'h4, 32'h0033);
    apb(1'b1, OFS_MODE0 + 8'h8, 32'h0043);
    apb(1'b1, OFS_CYC0, 32'h4);
    apb(1'b1, OFS_CYC0 + 8'h4, 32'h3);
    apb(1'b1, OFS_CYC0 + 8'h8, 32'h2);
    term.pulse(1'b1, 3'h7);
    term.set_lvl(3'h0, 1'b1);
    repeat (400) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0 + 8'h4, stat_model(3, 0, 1, 1, 1), 32'hffffffff);
    rd_chk(OFS_STAT0 + 8'h8, stat_model(2, 0, 1, 1, 1), 32'hffffffff);
    rd_chk(OFS_STAT0, stat_model(0, 1, 0, 0, 0), 32'h10000);
    check(32'(timer_out_o[2:1]), 32'h3);
    $display("test chained start done");
    // stop-triggered starts, auto resets, third timer on second
    term.pulse(1'b1, 3'h7);
    apb(1'b1, OFS_MODE0, 32'h0120);
    apb(1'b1, OFS_CYC0, 32'h3);
    apb(1'b1, OFS_MODE0 + 8'h4, 32'h0220);
    apb(1'b1, OFS_CYC0 + 8'h4, 32'h2);
    apb(1'b1, OFS_MODE0 + 8'h8, 32'h0054);
    apb(1'b1, OFS_CYC0 + 8'h8, 32'h5);
    term.set_lvl(3'h0, 1'b0);
    repeat (200) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0, stat_model(0, 0, 0, 1, 0), 32'h5ffff);
    rd_chk(OFS_STAT0 + 8'h4, 0, 32'h1ffff);
    rd_chk(OFS_STAT0 + 8'h8, stat_model(1, 1, 0, 0, 0), 32'h1ffff);
    $display("test stop start done");
    // pulse and toggle outputs; modes first so the terminal reset applies
    apb(1'b1, OFS_OSEL, 32'h630);
    apb(1'b1, OFS_MODE0, 32'h0);
    apb(1'b1, OFS_MODE0 + 8'h4, 32'h0033);
    apb(1'b1, OFS_CYC0 + 8'h4, 32'h1);
    apb(1'b1, OFS_CMP0 + 8'h8, 32'h1);
    term.pulse(1'b1, 3'h7);
    term.pulse(1'b0, 3'h1);
    repeat (200) @(posedge clk_sys_i);
    rd_chk(OFS_STAT0, stat_model(3, 0, 1, 1, 1), 32'hffffffff);
    rd_chk(OFS_STAT0 + 8'h4, stat_model(1, 0, 1, 1, 1), 32'hffffffff);
    rd_chk(OFS_STAT0 + 8'h8, stat_model(1, 1, 1, 0, 1), 32'hffffffff);
    check(32'(timer_out_o), 32'h7);
    $display("test output modes done");
    complete_run();
  end
endmodule
